// ---- verilog/chan_buf.sv ----
// Channel run control, configuration switch and circular frame buffer addressing
`timescale 1ns/100ps
module chan_buf
    import chan_buf_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter logic [7:0] ERR_CODE = CAT3_CODE_DEFAULT
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic is_transmit,
    input wire logic superframe_sync,
    input wire logic frame_done,
    input wire logic config_error,
    output logic channel_running,
    output logic use_set_b,
    output logic [SEL_W-1:0] applied_selection,
    output logic [31:0] frame_address,
    output logic [FLD_W-1:0] transfer_bytes,
    output logic [COUNT_W-1:0] frame_index,
    output logic irq
);
    run_state_t state_q, state_d;
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic run_q, run_d;
    logic [SEL_W-1:0] sel_q, sel_d, act_q, act_d;
    logic [31:0] base_q, base_d;
    logic [FLD_W-1:0] stride_q, stride_d, size_q, size_d;
    logic [COUNT_W-1:0] count_q, count_d, idx_q, idx_d;
    logic [31:0] faddr_q, faddr_d;
    logic [31:0] err_q, err_d;
    logic [IRQ_W-1:0] ista_q, ista_d, imask_q, imask_d;
    logic [IRQ_W-1:0] ev;
    logic req, wr, rd;
    logic last_frame;
    logic [7:0] adr;
    logic [31:0] wmask, wval;

    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr = req && wb_we_i;
    assign rd = req && !wb_we_i;
    assign adr = 8'(wb_adr_i);

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
        end
    end

    // Byte lanes not enabled leave the stored bits alone
    assign wval = wb_dat_i & wmask;
    assign last_frame = (idx_q + 8'h01 >= count_q);

    // Bus answer: ack one cycle after the request is taken
    always_comb begin
        ack_d = req;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    // Software settings
    always_comb begin
        run_d = run_q;
        sel_d = sel_q;
        base_d = base_q;
        stride_d = stride_q;
        size_d = size_q;
        count_d = count_q;
        imask_d = imask_q;
        if (wr) begin
            if (adr == ADDR_RUN) begin
                run_d = (wb_dat_i[RUN_BIT] & wb_sel_i[0]) | (run_q & !wb_sel_i[0]);
                sel_d = wval[SEL_HI:SEL_LO] | (sel_q & ~wmask[SEL_HI:SEL_LO]);
            end else if (adr == ADDR_BASE) begin
                base_d = {wval[31:2] | (base_q[31:2] & ~wmask[31:2]), ALIGN_ZERO};
            end else if (adr == ADDR_STRIDE) begin
                stride_d = {(wval[FLD_W-1:2] | (stride_q[FLD_W-1:2] & ~wmask[FLD_W-1:2])), ALIGN_ZERO};
            end else if (adr == ADDR_SIZE) begin
                size_d = {(wval[FLD_W-1:2] | (size_q[FLD_W-1:2] & ~wmask[FLD_W-1:2])), ALIGN_ZERO};
            end else if (adr == ADDR_COUNT) begin
                count_d = wval[COUNT_W-1:0] | (count_q & ~wmask[COUNT_W-1:0]);
            end else if (adr == ADDR_IRQ_MASK) begin
                imask_d = wval[IRQ_W-1:0] | (imask_q & ~wmask[IRQ_W-1:0]);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            run_q <= 1'b0;
            sel_q <= '0;
            base_q <= RESET_WORD;
            stride_q <= '0;
            size_q <= '0;
            count_q <= '0;
            imask_q <= '0;
        end else begin
            run_q <= run_d;
            sel_q <= sel_d;
            base_q <= base_d;
            stride_q <= stride_d;
            size_q <= size_d;
            count_q <= count_d;
            imask_q <= imask_d;
        end
    end

    // Held selection moves over only at the superframe boundary
    always_comb begin
        act_d = act_q;
        if (superframe_sync && (act_q != sel_d)) begin
            act_d = sel_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            act_q <= '0;
        end else begin
            act_q <= act_d;
        end
    end

    // Error entry: a later error overwrites, there is no queue here
    always_comb begin
        err_d = err_q;
        if (config_error) begin
            err_d = {ERR_CODE, CAT3_MID, 8'(act_q)};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            err_q <= RESET_WORD;
        end else begin
            err_q <= err_d;
        end
    end

    // Events that feed the sticky status bits
    always_comb begin
        ev = '0;
        ev[IRQ_CFG] = superframe_sync && (act_q != sel_d);
        if (frame_done && state_q == ST_RUN) begin
            ev[IRQ_FRAME] = 1'b1;
            ev[IRQ_WRAP] = last_frame;
        end
    end

    // Read data stands for the ack cycle only, zero otherwise
    always_comb begin
        rdata_d = RESET_WORD;
        if (rd) begin
            if (adr == ADDR_RUN) begin
                rdata_d = {15'h0000, sel_q, 7'h00, run_q};
            end else if (adr == ADDR_BASE) begin
                rdata_d = base_q;
            end else if (adr == ADDR_STRIDE) begin
                rdata_d = {20'h00000, stride_q};
            end else if (adr == ADDR_SIZE) begin
                rdata_d = {20'h00000, size_q};
            end else if (adr == ADDR_COUNT) begin
                rdata_d = {24'h000000, count_q};
            end else if (adr == ADDR_FRAME_ADDR) begin
                rdata_d = faddr_q;
            end else if (adr == ADDR_ERR_ENTRY) begin
                rdata_d = err_q;
            end else if (adr == ADDR_IRQ_STATUS) begin
                rdata_d = {29'h00000000, ista_q};
            end else if (adr == ADDR_IRQ_MASK) begin
                rdata_d = {29'h00000000, imask_q};
            end else if (adr == ADDR_STATUS) begin
                rdata_d = {15'h0000, act_q, 6'h00, state_q};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= RESET_WORD;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // New events win over the clear by read
    always_comb begin
        if (rd && adr == ADDR_IRQ_STATUS) begin
            ista_d = ev;
        end else begin
            ista_d = ista_q | ev;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ista_q <= '0;
        end else begin
            ista_q <= ista_d;
        end
    end

    // Address walker: restarts at index zero on every start
    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        faddr_d = faddr_q;
        case (state_q)
            ST_IDLE: begin
                idx_d = '0;
                faddr_d = base_q;
                if (run_q) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!run_q) begin
                    state_d = ST_IDLE;
                end else if (frame_done) begin
                    // A count of zero behaves as one frame per buffer
                    if (idx_q + 8'h01 >= count_q) begin
                        idx_d = '0;
                        faddr_d = base_q;
                    end else begin
                        idx_d = idx_q + 8'h01;
                        faddr_d = faddr_q + {20'h00000, stride_q};
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            idx_q <= '0;
            faddr_q <= RESET_WORD;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            faddr_q <= faddr_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign channel_running = (state_q == ST_RUN);
    assign applied_selection = act_q;
    assign use_set_b = act_q[0];
    assign frame_address = faddr_q;
    assign frame_index = idx_q;
    // Receive channels fill whatever arrives, so transfer_bytes is zero for them while the size register still reads back
    assign transfer_bytes = is_transmit ? size_q : '0;
    assign irq = |(ista_q & imask_q);
endmodule

// ---- verilog/chan_buf_pkg.sv ----
// Constants for the channel buffer addressing block
package chan_buf_pkg;
    localparam logic [7:0] ADDR_RUN = 8'h00;
    localparam logic [7:0] ADDR_BASE = 8'h04;
    localparam logic [7:0] ADDR_STRIDE = 8'h08;
    localparam logic [7:0] ADDR_SIZE = 8'h0c;
    localparam logic [7:0] ADDR_COUNT = 8'h10;
    localparam logic [7:0] ADDR_FRAME_ADDR = 8'h14;
    localparam logic [7:0] ADDR_ERR_ENTRY = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;
    localparam int RUN_BIT = 0;
    localparam int SEL_LO = 8;
    localparam int SEL_HI = 16;
    localparam int SEL_W = 9;
    localparam int FLD_W = 12;
    localparam int COUNT_W = 8;
    localparam int CODE_LO = 24;
    localparam int IRQ_W = 3;
    localparam int IRQ_FRAME = 0;
    localparam int IRQ_WRAP = 1;
    localparam int IRQ_CFG = 2;
    localparam logic [1:0] ALIGN_ZERO = 2'h0;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [15:0] CAT3_MID = 16'h0000;
    localparam logic [7:0] CAT3_CODE_DEFAULT = 8'h03;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01
    } run_state_t;
endpackage

// ---- test/chan_buf_assertions.sv ----
// Port checker for the channel buffer block
`timescale 1ns/100ps
module chan_buf_assertions
    import chan_buf_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic is_transmit,
    input wire logic superframe_sync,
    input wire logic channel_running,
    input wire logic use_set_b,
    input wire logic [SEL_W-1:0] applied_selection,
    input wire logic [31:0] frame_address,
    input wire logic [FLD_W-1:0] transfer_bytes,
    input wire logic [COUNT_W-1:0] frame_index
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    sel_hold_a: assert property (!superframe_sync |=> $stable(applied_selection)) else $error("early switch");
    set_pick_a: assert property (use_set_b == applied_selection[0]) else $error("wrong set");
    rx_size_a: assert property (!is_transmit |-> transfer_bytes == 12'h000) else $error("rx size");
    size_align_a: assert property (transfer_bytes[1:0] == ALIGN_ZERO) else $error("size align");
    addr_align_a: assert property (frame_address[1:0] == ALIGN_ZERO) else $error("addr align");
    start_zero_a: assert property ($rose(channel_running) |-> frame_index == 8'h00) else $error("start");
    cover property (superframe_sync && !use_set_b);
    cover property ($rose(channel_running));
    cover property (is_transmit && transfer_bytes != 12'h000);
endmodule
bind chan_buf chan_buf_assertions u_chk (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .is_transmit(is_transmit), .superframe_sync(superframe_sync),
    .channel_running(channel_running), .use_set_b(use_set_b), .applied_selection(applied_selection),
    .frame_address(frame_address), .transfer_bytes(transfer_bytes), .frame_index(frame_index));

// ---- test/link_mem_model.sv ----
// Far side model: frame mover and superframe timing
`timescale 1ns/100ps
module link_mem_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic running,
    input wire logic [3:0] gap,
    input wire logic sync_req,
    output logic frame_done,
    output logic superframe_sync
);
    logic [3:0] cnt_q;
    // Frames move only while running; gap gives prompt or slow pacing
    always_ff @(posedge clk) begin
        if (srst || !running) begin
            cnt_q <= 4'h0;
            frame_done <= 1'b0;
        end else begin
            cnt_q <= (cnt_q >= gap) ? 4'h0 : cnt_q + 4'h1;
            frame_done <= (cnt_q >= gap);
        end
        superframe_sync <= !srst && sync_req;
    end
endmodule

// ---- test/chan_buf_tb.sv ----
// Self-checking bench for the channel buffer block
`timescale 1ns/100ps
module chan_buf_tb;
    import chan_buf_pkg::*;
    logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, is_tx = 1'b0, sync_req = 1'b0, cfg_err = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf, gap = 4'h2;
    logic [31:0] dat = 32'h0, q, rdat, faddr;
    logic ack, sf, fd, run, setb, irq;
    logic [SEL_W-1:0] appsel;
    logic [FLD_W-1:0] tbytes;
    logic [COUNT_W-1:0] fidx;
    int n_fail = 0, cmp_count = 0, cycles = 0;
    always #2.5 clk = ~clk;
    chan_buf DUT (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .is_transmit(is_tx), .superframe_sync(sf),
        .frame_done(fd), .config_error(cfg_err), .channel_running(run), .use_set_b(setb), .irq(irq),
        .applied_selection(appsel), .frame_address(faddr), .transfer_bytes(tbytes), .frame_index(fidx));
    link_mem_model far (.clk(clk), .srst(srst), .running(run), .gap(gap), .sync_req(sync_req), .frame_done(fd),
        .superframe_sync(sf));
    task automatic end_of_test();
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Request held until ack is sampled high; the wait is bounded by the cycle ceiling
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
        bus(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            end_of_test();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        bus(1'b1, ADDR_BASE, 32'h1234_5677);
        bus(1'b1, ADDR_STRIDE, 32'hffff_f0ff);
        bus(1'b1, ADDR_SIZE, 32'h0000_0abf);
        bus(1'b1, ADDR_COUNT, 32'h0000_0003);
        bus(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
        rc(ADDR_BASE, 32'h1234_5674, "base");
        rc(ADDR_STRIDE, 32'h0000_00fc, "stride");
        rc(ADDR_SIZE, 32'h0000_0abc, "size");
        rc(8'h3c, 32'h0, "unmapped");
        chk("rx size", 32'h0, 32'(tbytes));
        is_tx <= 1'b1;
        repeat (2) @(posedge clk);
        chk("tx size", 32'h0abc, 32'(tbytes));
        bus(1'b1, ADDR_RUN, 32'h0001_0100);
        chk("held sel", 32'h0, 32'(appsel));
        sync_req <= 1'b1;
        @(posedge clk);
        sync_req <= 1'b0;
        repeat (3) @(posedge clk);
        chk("applied sel", 32'h101, 32'(appsel));
        chk("set b", 32'h1, 32'(setb));
        cfg_err <= 1'b1;
        @(posedge clk);
        cfg_err <= 1'b0;
        rc(ADDR_ERR_ENTRY, {CAT3_CODE_DEFAULT, CAT3_MID, 8'h01}, "error entry");
        bus(1'b1, ADDR_RUN, 32'h0001_0101);
        chk("running", 32'h1, 32'(run));
        chk("start addr", 32'h1234_5674, faddr);
        for (int k = 1; k <= 4; k++) begin
            gap <= (k > 2) ? 4'h9 : 4'h2;
            @(posedge clk iff fd);
            @(posedge clk);
            chk("frame addr", 32'h1234_5674 + (k % 3) * 32'h0fc, faddr);
        end
        chk("frame index", 32'h1, 32'(fidx));
        chk("irq on", 32'h1, 32'(irq));
        bus(1'b1, ADDR_RUN, 32'h0001_0100);
        chk("stopped", 32'h0, 32'(run));
        rc(ADDR_IRQ_STATUS, 32'h7, "irq status");
        chk("irq off", 32'h0, 32'(irq));
        rc(ADDR_IRQ_STATUS, 32'h0, "status cleared");
        rc(ADDR_RUN, 32'h0001_0100, "run reg");
        rc(ADDR_COUNT, 32'h0000_0003, "count");
        rc(ADDR_FRAME_ADDR, 32'h1234_5674, "idle frame addr");
        rc(ADDR_IRQ_MASK, 32'h0000_0001, "mask");
        rc(ADDR_STATUS, 32'h0001_0100, "status");
        sel <= 4'h2;
        bus(1'b1, ADDR_BASE, 32'hffff_ab00);
        sel <= 4'hf;
        rc(ADDR_BASE, 32'h1234_ab74, "lane write");
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rc(ADDR_BASE, 32'h0, "reset base");
        end_of_test();
    end
endmodule
